// >>> fpx_pkg.sv
// Shared types and constants for the floating-point exception unit
`default_nettype none
package fpx_pkg;
    // ****************************************************************
    // Fault vectors and encodings
    // ****************************************************************
    localparam logic [7:0] VEC_INVALID_OPCODE = 8'h06;
    localparam logic [7:0] VEC_DEVICE_UNAVAIL = 8'h07;
    localparam logic [7:0] VEC_ALIGNMENT = 8'h11;
    localparam logic [7:0] VEC_SEGMENT_ABSENT = 8'h0B;
    localparam logic [7:0] VEC_FP_ERROR = 8'h10;
    localparam logic [7:0] VEC_NONE = 8'h00;
    localparam logic [1:0] PRIV_USER = 2'h3;
    localparam logic [1:0] RC_CHOP = 2'h3;
    localparam logic [1:0] PC_EXTENDED = 2'h3;
    // Status flag positions in the 6-bit exception vector
    localparam int EX_IE = 0;
    localparam int EX_DE = 1;
    localparam int EX_ZE = 2;
    localparam int EX_OE = 3;
    localparam int EX_UE = 4;
    localparam int EX_PE = 5;
    localparam logic [5:0] EX_RESET = 6'h00;
    localparam logic [31:0] IP_RESET = 32'h0;

    typedef enum logic [2:0] {
        OP_ARITH, OP_TRANSCEND, OP_EXTRACT, OP_SQRT_DIV_REM, OP_CONVERT, OP_ENV_LOAD, OP_SAVE_RESTORE
    } op_class_e;

    // One instruction presented by the core
    typedef struct packed {
        logic defined;
        op_class_e cls;
        logic [31:0] prefix_ip;
        logic misaligned;
        logic stack_part;
        logic [1:0] priv;
        logic denormal_in;
        logic overflow;
        logic tiny;
        logic inexact_denorm;
        logic dest_stack;
        logic pc_applies;
        logic env_first_ok;
        logic env_last_ok;
        logic seg_overrun;
        logic [5:0] other_ex;
    } fp_instr_s;

    // Outcome reported back for one instruction
    typedef struct packed {
        logic [7:0] vector;
        logic abort;
        logic normalize;
        logic saturate;
        logic round_result;
        logic [1:0] round_prec;
        logic env_commit;
        logic [5:0] flags;
    } fp_result_s;
endpackage
`default_nettype wire

// >>> fpx_prio.sv
// Fault prioritiser for arithmetic exceptions
`default_nettype none
module fpx_prio (
    // Raised exceptions and mask
    input wire logic [5:0] raised,
    input wire logic [5:0] mask,
    // Unmasked exceptions and their OR
    output logic [5:0] unmasked,
    output logic any_unmasked
);
    // Same ordering regardless of the denormal mask setting
    always_comb begin
        unmasked = raised & ~mask;
        any_unmasked = |unmasked;
    end
endmodule
`default_nettype wire

// >>> fpx_ipreg.sv
// Holds the instruction pointer captured for a faulting instruction
`default_nettype none
module fpx_ipreg (
    input wire logic clk,
    input wire logic resetn,
    input wire logic load,
    input wire logic [31:0] ip_in,
    output logic [31:0] ip_q
);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ip_q <= fpx_pkg::IP_RESET;
        end else if (load) begin
            ip_q <= ip_in;
        end
    end
endmodule
`default_nettype wire

// >>> fp_exception_handling_unit.sv
// Floating-point exception handling unit
`default_nettype none
// Overview of operation
// - Masked denormal: normalize, never return denormal
// - Denormal fault also for transcendentals, extract
// - Masked overflow with chop gives largest finite
// - Unmasked overflow sets precision; round stack result
// - Masked underflow only when tiny and inexact
// - Unmasked underflow: adjust exponent then round
// - Denormal priority independent of its mask
// - Saved pointer points at first prefix
// - Undefined opcode gives vector 6, no checks
// - Task-switched or emulate flag gives vector 7
// - Unmasked fault asserts error pin at completion
// - Next FP instruction blocked while fault pending
// - Sqrt/divide/remainder/convert normalize denormals first
// - Misaligned operand at level 3 raises alignment
// - Environment load checks both ends first
// - Segment overrun aborts, never interrupt 9
module fp_exception_handling_unit (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Instruction issue
    input wire logic issue,
    input wire fpx_pkg::fp_instr_s instr,
    output logic issue_ready_q,
    // Control state
    input wire logic task_switched_flag,
    input wire logic emulate_fp_flag,
    input wire logic align_check_en,
    input wire logic [5:0] mask_bits,
    input wire logic [1:0] rounding_ctrl,
    input wire logic [1:0] precision_control_field,
    // Software clear of pending flags
    input wire logic clear_flags,
    // Results
    output fpx_pkg::fp_result_s result_q,
    output logic result_valid_q,
    output logic [5:0] status_flags_q,
    output logic [31:0] saved_instruction_pointer,
    output logic fp_error_out_n
);
    // ****************************************************************
    // Exception evaluation
    // ****************************************************************
    logic [5:0] raised;
    logic [5:0] unmasked;
    logic any_unmasked;
    logic pending_q;
    logic err_n_q;
    logic is_fault;
    logic denorm_cls;
    fpx_pkg::fp_result_s res_d;

    function automatic logic prenorm_cls(input fpx_pkg::op_class_e cls);
        return cls inside {fpx_pkg::OP_SQRT_DIV_REM, fpx_pkg::OP_CONVERT};
    endfunction

    fpx_prio u_prio (
        .raised(raised),
        .mask(mask_bits),
        .unmasked(unmasked),
        .any_unmasked(any_unmasked)
    );

    always_comb begin
        raised = instr.other_ex;
        denorm_cls = instr.cls != fpx_pkg::OP_ENV_LOAD && instr.cls != fpx_pkg::OP_SAVE_RESTORE;
        if (instr.denormal_in && denorm_cls) begin
            raised[fpx_pkg::EX_DE] = 1'b1;
        end
        if (instr.overflow) begin
            raised[fpx_pkg::EX_OE] = 1'b1;
            if (!mask_bits[fpx_pkg::EX_OE]) begin
                raised[fpx_pkg::EX_PE] = 1'b1;
            end
        end
        // masked underflow needs tiny and loss
        if (instr.tiny) begin
            if (!mask_bits[fpx_pkg::EX_UE] || instr.inexact_denorm) begin
                raised[fpx_pkg::EX_UE] = 1'b1;
            end
        end
        // no invalid fault from denormals here
        if (instr.denormal_in && prenorm_cls(instr.cls)) begin
            raised[fpx_pkg::EX_IE] = instr.other_ex[fpx_pkg::EX_IE];
        end
    end

    always_comb begin
        res_d = '0;
        res_d.vector = fpx_pkg::VEC_NONE;
        res_d.round_prec = fpx_pkg::PC_EXTENDED;
        is_fault = 1'b1;
        if (task_switched_flag || emulate_fp_flag) begin
            res_d.vector = fpx_pkg::VEC_DEVICE_UNAVAIL;
        end else if (!instr.defined) begin
            res_d.vector = fpx_pkg::VEC_INVALID_OPCODE;
        end else if (align_check_en && instr.priv == fpx_pkg::PRIV_USER
                && instr.misaligned && !instr.stack_part) begin
            res_d.vector = fpx_pkg::VEC_ALIGNMENT;
        end else if (instr.cls == fpx_pkg::OP_ENV_LOAD
                && !(instr.env_first_ok && instr.env_last_ok)) begin
            // no state change when probes fail
            res_d.vector = fpx_pkg::VEC_SEGMENT_ABSENT;
        end else if (instr.seg_overrun) begin
            res_d.abort = 1'b1;
        end else begin
            is_fault = 1'b0;
            res_d.flags = raised;
            res_d.env_commit = instr.cls == fpx_pkg::OP_ENV_LOAD;
            res_d.normalize = instr.denormal_in && (mask_bits[fpx_pkg::EX_DE]
                || prenorm_cls(instr.cls));
            // saturate on masked overflow under chop
            res_d.saturate = instr.overflow && mask_bits[fpx_pkg::EX_OE]
                && rounding_ctrl == fpx_pkg::RC_CHOP;
            if (instr.dest_stack && ((instr.overflow && !mask_bits[fpx_pkg::EX_OE])
                    || (instr.tiny && !mask_bits[fpx_pkg::EX_UE]))) begin
                res_d.round_result = 1'b1;
                res_d.round_prec = instr.pc_applies ? precision_control_field
                    : fpx_pkg::PC_EXTENDED;
            end
            if (any_unmasked) begin
                res_d.vector = fpx_pkg::VEC_FP_ERROR;
            end
        end
    end

    // ****************************************************************
    // Sequencing
    // ****************************************************************
    logic accept;
    // Refused issues are dropped, not queued: the core must hold issue up
    // issue blocked while unmasked fault pending
    assign accept = issue && !pending_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            result_q <= '0;
            result_valid_q <= 1'b0;
        end else begin
            result_valid_q <= accept;
            if (accept) begin
                result_q <= res_d;
            end
        end
    end

    fpx_ipreg u_ip (
        .clk(clk),
        .resetn(resetn),
        .load(accept && (is_fault || any_unmasked || res_d.abort)),
        .ip_in(instr.prefix_ip),
        .ip_q(saved_instruction_pointer)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_flags_q <= fpx_pkg::EX_RESET;
        end else if (accept && !is_fault) begin
            status_flags_q <= (clear_flags ? fpx_pkg::EX_RESET : status_flags_q) | res_d.flags;
        end else if (clear_flags) begin
            status_flags_q <= fpx_pkg::EX_RESET;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pending_q <= 1'b0;
            err_n_q <= 1'b1;
            issue_ready_q <= 1'b1;
        end else begin
            // held until flags cleared; set wins
            if (accept && !is_fault && any_unmasked) begin
                pending_q <= 1'b1;
                err_n_q <= 1'b0;
                issue_ready_q <= 1'b0;
            end else if (clear_flags) begin
                pending_q <= 1'b0;
                err_n_q <= 1'b1;
                issue_ready_q <= 1'b1;
            end
        end
    end
    // pin goes to an outside interrupt controller
    assign fp_error_out_n = err_n_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_err_follows_fault: assert property (@(posedge clk) disable iff (!resetn)
        accept && !is_fault && any_unmasked |=> !fp_error_out_n && !issue_ready_q)
        else $error("error pin not asserted after unmasked fault");
    chk_err_holds: assert property (@(posedge clk) disable iff (!resetn)
        !fp_error_out_n && !clear_flags |=> !fp_error_out_n)
        else $error("error pin dropped without clear");
    chk_block_next: assert property (@(posedge clk) disable iff (!resetn)
        !issue_ready_q |=> !result_valid_q)
        else $error("instruction issued while fault pending");
    chk_dev_unavail: assert property (@(posedge clk) disable iff (!resetn)
        accept && (task_switched_flag || emulate_fp_flag)
        |=> result_q.vector == fpx_pkg::VEC_DEVICE_UNAVAIL)
        else $error("device unavailable not raised");
    chk_undef_op: assert property (@(posedge clk) disable iff (!resetn)
        accept && !instr.defined && !task_switched_flag && !emulate_fp_flag
        |=> result_q.vector == fpx_pkg::VEC_INVALID_OPCODE && result_q.flags == 6'h00)
        else $error("undefined opcode not faulted cleanly");
    chk_chop_sat: assert property (@(posedge clk) disable iff (!resetn)
        accept && !is_fault && !res_d.abort && instr.overflow
        && mask_bits[fpx_pkg::EX_OE] && rounding_ctrl == fpx_pkg::RC_CHOP
        |=> result_q.saturate)
        else $error("chop overflow not saturated");
    chk_env_probe: assert property (@(posedge clk) disable iff (!resetn)
        accept && instr.cls == fpx_pkg::OP_ENV_LOAD
        && !(instr.env_first_ok && instr.env_last_ok) |=> !result_q.env_commit)
        else $error("environment committed after failed probe");
    chk_ip_prefix: assert property (@(posedge clk) disable iff (!resetn)
        accept && is_fault |=> saved_instruction_pointer == $past(instr.prefix_ip))
        else $error("saved pointer is not the prefix address");
    chk_overrun: assert property (@(posedge clk) disable iff (!resetn)
        accept && instr.seg_overrun && instr.defined && !task_switched_flag && !emulate_fp_flag
        && !align_check_en && instr.cls != fpx_pkg::OP_ENV_LOAD
        |=> result_q.abort && result_q.vector != 8'h09)
        else $error("overrun did not abort cleanly");
    chk_pe_unmasked_oe: assert property (@(posedge clk) disable iff (!resetn)
        accept && !is_fault && instr.overflow && !mask_bits[fpx_pkg::EX_OE]
        |=> result_q.flags[fpx_pkg::EX_PE])
        else $error("precision not flagged on unmasked overflow");
    chk_of_round: assert property (@(posedge clk) disable iff (!resetn)
        accept && !is_fault && instr.dest_stack && instr.overflow && !mask_bits[fpx_pkg::EX_OE]
        |=> result_q.round_result)
        else $error("unmasked overflow to stack not rounded");
    chk_mask_normalize: assert property (@(posedge clk) disable iff (!resetn)
        accept && !is_fault && instr.denormal_in && mask_bits[fpx_pkg::EX_DE]
        |=> result_q.normalize)
        else $error("masked denormal not normalized");
    chk_de_transcend: assert property (@(posedge clk) disable iff (!resetn)
        accept && !is_fault && instr.denormal_in
        && instr.cls inside {fpx_pkg::OP_TRANSCEND, fpx_pkg::OP_EXTRACT}
        |=> result_q.flags[fpx_pkg::EX_DE])
        else $error("denormal not flagged for transcendental");
    chk_uf_masked: assert property (@(posedge clk) disable iff (!resetn)
        accept && !is_fault && mask_bits[fpx_pkg::EX_UE] && !instr.other_ex[fpx_pkg::EX_UE]
        && !(instr.tiny && instr.inexact_denorm)
        |=> !result_q.flags[fpx_pkg::EX_UE])
        else $error("masked underflow flagged without loss");
    chk_uf_round: assert property (@(posedge clk) disable iff (!resetn)
        accept && !is_fault && instr.dest_stack && instr.tiny && !mask_bits[fpx_pkg::EX_UE]
        |=> result_q.round_result && result_q.round_prec == ($past(instr.pc_applies)
        ? $past(precision_control_field) : fpx_pkg::PC_EXTENDED))
        else $error("unmasked underflow not rounded to precision");
    chk_de_prio: assert property (@(posedge clk) disable iff (!resetn)
        accept && instr.denormal_in && instr.defined && !task_switched_flag && !emulate_fp_flag
        && align_check_en && instr.priv == fpx_pkg::PRIV_USER && instr.misaligned
        && !instr.stack_part |=> result_q.vector == fpx_pkg::VEC_ALIGNMENT)
        else $error("denormal overtook a higher fault");
    chk_prenorm: assert property (@(posedge clk) disable iff (!resetn)
        accept && !is_fault && instr.denormal_in && prenorm_cls(instr.cls)
        && !instr.other_ex[fpx_pkg::EX_IE]
        |=> result_q.normalize && !result_q.flags[fpx_pkg::EX_IE])
        else $error("denormal operand not normalized first");
    chk_align: assert property (@(posedge clk) disable iff (!resetn)
        accept && instr.defined && !task_switched_flag && !emulate_fp_flag && align_check_en
        && instr.priv == fpx_pkg::PRIV_USER && instr.misaligned && !instr.stack_part
        |=> result_q.vector == fpx_pkg::VEC_ALIGNMENT)
        else $error("misaligned operand not faulted");
    chk_ip_unmasked: assert property (@(posedge clk) disable iff (!resetn)
        accept && !is_fault && any_unmasked
        |=> saved_instruction_pointer == $past(instr.prefix_ip))
        else $error("saved pointer missed on unmasked fault");
    chk_err_clears: assert property (@(posedge clk) disable iff (!resetn)
        clear_flags && !(accept && !is_fault && any_unmasked)
        |=> fp_error_out_n && issue_ready_q)
        else $error("error pin not released by clear");
    chk_flags_clear: assert property (@(posedge clk) disable iff (!resetn)
        clear_flags && !accept |=> status_flags_q == fpx_pkg::EX_RESET)
        else $error("status flags not cleared");
    chk_undef_quiet: assert property (@(posedge clk) disable iff (!resetn)
        accept && !instr.defined && !task_switched_flag && !emulate_fp_flag
        |=> fp_error_out_n)
        else $error("undefined opcode drove the error pin");

    // ****************************************************************
    // Cover points
    // ****************************************************************
    cov_fault: cover property (@(posedge clk) disable iff (!resetn)
        accept && !is_fault && any_unmasked);
    cov_clear: cover property (@(posedge clk) disable iff (!resetn)
        !fp_error_out_n ##1 fp_error_out_n);
    cov_align: cover property (@(posedge clk) disable iff (!resetn)
        accept && res_d.vector == fpx_pkg::VEC_ALIGNMENT);
    cov_round: cover property (@(posedge clk) disable iff (!resetn)
        accept && !is_fault && instr.overflow && instr.dest_stack);
    cov_refused: cover property (@(posedge clk) disable iff (!resetn)
        issue && pending_q);
endmodule
`default_nettype wire

// >>> fpx_irq_ctrl.sv
// Model of the outside interrupt controller fed by the error pin
`default_nettype none
module fpx_irq_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Error pin in, interrupt request out
    input wire logic fp_error_out_n,
    output logic maskable_interrupt_in
);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            maskable_interrupt_in <= 1'b0;
        end else begin
            maskable_interrupt_in <= !fp_error_out_n;
        end
    end
endmodule
`default_nettype wire

// >>> fp_exception_handling_unit_tb_top.sv
// Self-checking bench for the floating-point exception unit
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (a), (b)); end end
module fp_exception_handling_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic issue = 1'b0;
    fpx_pkg::fp_instr_s instr = '0;
    logic task_switched_flag = 1'b0;
    logic emulate_fp_flag = 1'b0;
    logic align_check_en = 1'b0;
    logic [5:0] mask_bits = 6'h3F;
    logic [1:0] rounding_ctrl = 2'h0;
    logic [1:0] precision_control_field = 2'h0;
    logic clear_flags = 1'b0;
    logic issue_ready_q, result_valid_q, fp_error_out_n, maskable_interrupt_in;
    fpx_pkg::fp_result_s result_q;
    logic [5:0] status_flags_q;
    logic [31:0] saved_instruction_pointer;
    int fails = 0;
    int cmp_count = 0;
    fpx_pkg::fp_instr_s i;

    fp_exception_handling_unit dut_u (.clk(clk), .resetn(resetn), .issue(issue), .instr(instr),
        .issue_ready_q(issue_ready_q), .task_switched_flag(task_switched_flag),
        .emulate_fp_flag(emulate_fp_flag), .align_check_en(align_check_en),
        .mask_bits(mask_bits), .rounding_ctrl(rounding_ctrl),
        .precision_control_field(precision_control_field), .clear_flags(clear_flags),
        .result_q(result_q), .result_valid_q(result_valid_q), .status_flags_q(status_flags_q),
        .saved_instruction_pointer(saved_instruction_pointer), .fp_error_out_n(fp_error_out_n));
    fpx_irq_ctrl irq_u (.clk(clk), .resetn(resetn), .fp_error_out_n(fp_error_out_n),
        .maskable_interrupt_in(maskable_interrupt_in));

    always #5 clk = ~clk;

    function automatic fpx_pkg::fp_instr_s base();
        fpx_pkg::fp_instr_s b;
        b = '0;
        b.defined = 1'b1;
        b.cls = fpx_pkg::OP_ARITH;
        b.priv = fpx_pkg::PRIV_USER;
        b.env_first_ok = 1'b1;
        b.env_last_ok = 1'b1;
        return b;
    endfunction

    // Result is registered, so it is judged one edge after issue
    task automatic run(input fpx_pkg::fp_instr_s x);
        @(posedge clk);
        #1 issue = 1'b1;
        instr = x;
        @(posedge clk);
        #1 issue = 1'b0;
    endtask

    task automatic clr();
        @(posedge clk);
        #1 clear_flags = 1'b1;
        @(posedge clk);
        #1 clear_flags = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic t_faults();
        i = base();
        i.defined = 1'b0;
        i.denormal_in = 1'b1;
        mask_bits = 6'h00;
        task_switched_flag = 1'b1;
        run(i);
        `CHK(result_q.vector, fpx_pkg::VEC_DEVICE_UNAVAIL)
        task_switched_flag = 1'b0;
        emulate_fp_flag = 1'b1;
        run(base());
        `CHK(result_q.vector, fpx_pkg::VEC_DEVICE_UNAVAIL)
        emulate_fp_flag = 1'b0;
        run(i);
        `CHK(result_q.vector, fpx_pkg::VEC_INVALID_OPCODE)
        `CHK(status_flags_q, 6'h00)
        `CHK(fp_error_out_n, 1'b1)
        align_check_en = 1'b1;
        i = base();
        i.misaligned = 1'b1;
        run(i);
        `CHK(result_q.vector, fpx_pkg::VEC_ALIGNMENT)
        i.cls = fpx_pkg::OP_SAVE_RESTORE;
        i.stack_part = 1'b1;
        run(i);
        `CHK(result_q.vector == fpx_pkg::VEC_ALIGNMENT, 1'b0)
        align_check_en = 1'b0;
        i = base();
        i.cls = fpx_pkg::OP_ENV_LOAD;
        i.env_first_ok = 1'b0;
        run(i);
        `CHK(result_q.vector, fpx_pkg::VEC_SEGMENT_ABSENT)
        i.env_first_ok = 1'b1;
        i.env_last_ok = 1'b0;
        run(i);
        `CHK(result_q.vector, fpx_pkg::VEC_SEGMENT_ABSENT)
        `CHK(result_q.env_commit, 1'b0)
        i.env_last_ok = 1'b1;
        run(i);
        `CHK(result_q.env_commit, 1'b1)
        i = base();
        i.seg_overrun = 1'b1;
        run(i);
        `CHK(result_q.abort, 1'b1)
        `CHK(result_q.vector == 8'h09, 1'b0)
        mask_bits = 6'h3F;
    endtask

    task automatic t_denorm();
        i = base();
        i.denormal_in = 1'b1;
        for (int c = 0; c < 5; c++) begin
            i.cls = fpx_pkg::op_class_e'(c);
            run(i);
            `CHK(result_q.normalize, 1'b1)
            `CHK(result_q.flags[fpx_pkg::EX_IE], 1'b0)
            `CHK(status_flags_q[fpx_pkg::EX_DE], 1'b1)
            `CHK(fp_error_out_n, 1'b1)
        end
        mask_bits = 6'h3D;
        i.cls = fpx_pkg::OP_SQRT_DIV_REM;
        run(i);
        `CHK(result_q.normalize, 1'b1)
        `CHK(fp_error_out_n, 1'b0)
        mask_bits = 6'h3F;
        clr();
    endtask

    task automatic t_over();
        i = base();
        i.overflow = 1'b1;
        rounding_ctrl = fpx_pkg::RC_CHOP;
        run(i);
        `CHK(result_q.saturate, 1'b1)
        clr();
        rounding_ctrl = 2'h0;
        mask_bits = 6'h37;
        precision_control_field = 2'h2;
        i.dest_stack = 1'b1;
        i.pc_applies = 1'b1;
        i.prefix_ip = 32'h1234_5670;
        run(i);
        `CHK(result_valid_q, 1'b1)
        `CHK(status_flags_q[fpx_pkg::EX_OE], 1'b1)
        `CHK(status_flags_q[fpx_pkg::EX_PE], 1'b1)
        `CHK(result_q.round_prec, 2'h2)
        `CHK(saved_instruction_pointer, 32'h1234_5670)
        `CHK(fp_error_out_n, 1'b0)
        `CHK(issue_ready_q, 1'b0)
        run(base());
        `CHK(result_valid_q, 1'b0)
        `CHK(result_q.vector, fpx_pkg::VEC_FP_ERROR)
        repeat (6) @(posedge clk);
        #1;
        `CHK(fp_error_out_n, 1'b0)
        `CHK(maskable_interrupt_in, 1'b1)
        clr();
        `CHK(fp_error_out_n, 1'b1)
        `CHK(issue_ready_q, 1'b1)
        `CHK(status_flags_q, fpx_pkg::EX_RESET)
    endtask

    task automatic t_under();
        mask_bits = 6'h3F;
        i = base();
        i.tiny = 1'b1;
        run(i);
        `CHK(status_flags_q[fpx_pkg::EX_UE], 1'b0)
        i.inexact_denorm = 1'b1;
        run(i);
        `CHK(status_flags_q[fpx_pkg::EX_UE], 1'b1)
        clr();
        mask_bits = 6'h2F;
        i.dest_stack = 1'b1;
        run(i);
        `CHK(result_q.round_result, 1'b1)
        `CHK(result_q.round_prec, fpx_pkg::PC_EXTENDED)
        clr();
        precision_control_field = 2'h1;
        i.pc_applies = 1'b1;
        run(i);
        `CHK(result_q.round_prec, 2'h1)
        clr();
        mask_bits = 6'h3F;
    endtask

    task automatic results();
        if (fails == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        #1 resetn = 1'b1;
        `CHK(fp_error_out_n, 1'b1)
        t_faults();
        t_denorm();
        t_over();
        t_under();
        results();
    end

    // Whole run needs under a hundred cycles
    initial begin
        #50000;
        fails++;
        results();
    end
endmodule
`default_nettype wire
